// ### src/iesp_pkg.sv
// Package: constants and carrier types for the status and poll block
package iesp_pkg;

    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned QUEUE_DEPTH  = 256;

    // Power-on values
    localparam logic [7:0] ESR_RESET     = 8'h80;
    localparam logic [7:0] ZERO_RESET    = 8'h00;

    // Event status bit positions
    localparam int unsigned EV_OPC       = 0;
    localparam int unsigned EV_QYE       = 2;
    localparam int unsigned EV_EXE       = 4;
    localparam int unsigned EV_CME       = 5;
    localparam int unsigned EV_PON       = 7;
    localparam logic [7:0] EV_USED_MASK  = 8'hb5;

    // Status byte bit positions
    localparam int unsigned SB_MAV       = 4;
    localparam int unsigned SB_ESB       = 5;
    localparam int unsigned SB_RQS       = 6;
    localparam logic [7:0] SB_USED_MASK  = 8'h30;

    // Query error codes
    localparam logic [7:0] QE_INTERRUPTED  = 8'h01;
    localparam logic [7:0] QE_DEADLOCK     = 8'h02;
    localparam logic [7:0] QE_UNTERMINATED = 8'h03;

    // Parallel poll enable byte layout
    localparam logic [2:0] PPE_TAG       = 3'h6;
    localparam int unsigned PPE_TAG_LSB  = 4;
    localparam int unsigned PPE_SENSE    = 3;

    // Interface function capability subsets, as ASCII pairs
    localparam logic [15:0] CAP_TALKER     = 16'h5436;
    localparam logic [15:0] CAP_LISTENER   = 16'h4c34;
    localparam logic [15:0] CAP_CONTROLLER = 16'h4330;

    typedef enum logic [3:0] {
        IESP_CMD_NONE   = 4'h0,
        IESP_CMD_ESE_W  = 4'h1,
        IESP_CMD_ESE_R  = 4'h2,
        IESP_CMD_ESR_R  = 4'h3,
        IESP_CMD_SRE_W  = 4'h4,
        IESP_CMD_SRE_R  = 4'h5,
        IESP_CMD_STB_R  = 4'h6,
        IESP_CMD_PRE_W  = 4'h7,
        IESP_CMD_PRE_R  = 4'h8,
        IESP_CMD_OPC    = 4'h9,
        IESP_CMD_QER_R  = 4'ha,
        IESP_CMD_EER_R  = 4'hb,
        IESP_CMD_RST    = 4'hc
    } iesp_cmd_t;

    // Common command request from the parser
    typedef struct packed {
        logic      valid;
        iesp_cmd_t cmd;
        logic [7:0] data;
    } iesp_req_t;

    // Parser and formatter events
    typedef struct packed {
        logic       syntax_err;
        logic       exec_err;
        logic [7:0] exec_code;
        logic       talk_addr;
        logic       fmt_idle;
        logic       fmt_waiting;
        logic       queue_empty;
        logic       pmt_read;
        logic       multi_end;
        logic       rmt_sent;
        logic       resp_ready;
    } iesp_evt_t;

    // Parallel poll configuration
    typedef struct packed {
        logic       enabled;
        logic       sense;
        logic [2:0] line;
    } iesp_ppcfg_t;

    typedef enum logic [1:0] {
        IESP_RESP_IDLE = 2'b00,
        IESP_RESP_WAIT = 2'b01,
        IESP_RESP_SEND = 2'b11
    } iesp_resp_t;

endpackage

// ### src/iesp_queue_level.sv
// Fill counter of the raw input queue with full and empty flags
`timescale 1ns/1ps
module iesp_queue_level #(
    parameter int unsigned DEPTH = iesp_pkg::QUEUE_DEPTH
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    input  wire logic                     flush_i,
    input  wire logic                     push_i,
    input  wire logic                     pop_i,
    output logic [$clog2(DEPTH+1)-1:0]    level_o,
    output logic                          full_o,
    output logic                          empty_o
);
    localparam int unsigned LW = $clog2(DEPTH + 1);
    localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);
    localparam logic [LW-1:0] ONE      = LW'(1);

    logic do_push;
    logic do_pop;

    assign do_push = push_i && (level_o != FULL_LVL);
    assign do_pop  = pop_i && (level_o != '0);

    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && flush_i)) begin
            level_o <= '0;
        end else if (ce_i) begin
            if (do_push && !do_pop) begin
                level_o <= level_o + ONE;
            end else if (do_pop && !do_push) begin
                level_o <= level_o - ONE;
            end
        end
    end

    assign full_o  = (level_o == FULL_LVL);
    assign empty_o = (level_o == '0);
endmodule

// ### src/iesp_status_poll.sv
// Status reporting, query error handling and parallel poll of the bus port
// Operation
// - Talker T6, listener L4 subsets, no controller capability.
// - Talk addressed, formatter idle, queue empty: query error, code 3.
// - Response pending and terminator or two ENDs: query error, code 1.
// - Response pending and queue full: query error code 2, formatter reset.
// - ist is set when poll enable AND status byte is nonzero.
// - Poll enable byte accepted when bits 6..4 are 110; sense, line.
// - Poll enable register written and read by common commands.
// - Event summary bit 5 follows enabled event status bits.
// - Event status read clears it; its enable is read and written.
// - Event bit 7 set at power-on; bits 6, 3, 1 unused.
// - Syntax error sets event bit 5 and resets the parser.
// - Execution failure sets event bit 4 and stores its code.
// - Event bit 2 on query error, bit 0 on operation complete.
// - Enabled status byte bit sets bit 6 and requests service.
// - Bit 6 is summary on query, request flag on serial poll.
// - Service request enable written and read by common commands.
// - Bit 4 set when response ready, cleared after terminator.
// - Power-on: event status 128, every other register zero.
// - After power-on the device is local with keys accepted.
// - Storage fault at power-up warns and restores defaults.
// - Input queue holds 256 bytes; full drives deadlock.
`timescale 1ns/1ps
module iesp_status_poll #(
    parameter int unsigned QUEUE_DEPTH = iesp_pkg::QUEUE_DEPTH
) (
    input  wire logic                  CLOCK_I,
    input  wire logic                  SYS_RST_I,
    input  wire logic                  CE_I,
    input  wire iesp_pkg::iesp_req_t   REQ_I,
    input  wire iesp_pkg::iesp_evt_t   EVT_I,
    input  wire logic                  Q_PUSH_I,
    input  wire logic                  Q_POP_I,
    input  wire logic                  PPE_VALID_I,
    input  wire logic [7:0]            PPE_BYTE_I,
    input  wire logic                  PPU_I,
    input  wire logic                  SPOLL_I,
    input  wire logic                  REN_I,
    input  wire logic                  LISTEN_CMD_I,
    input  wire logic                  LOCAL_KEY_I,
    input  wire logic                  NVRAM_FAULT_I,
    output logic [7:0]                 RESP_DATA_O,
    output logic                       RESP_VALID_O,
    output logic [7:0]                 SPOLL_BYTE_O,
    output logic                       SRQ_O,
    output logic                       IST_O,
    output logic [7:0]                 PP_DIO_O,
    output logic [7:0]                 PP_DIO_OE_O,
    output logic                       PARSER_RESET_O,
    output logic                       FMT_RESET_O,
    output logic                       QUEUE_FULL_O,
    output logic                       REMOTE_O,
    output logic                       KEYS_ENABLED_O,
    output logic                       NV_WARN_O,
    output logic                       DEFAULTS_LOAD_O,
    output logic [15:0]                CAP_TALKER_O,
    output logic [15:0]                CAP_LISTENER_O,
    output logic [15:0]                CAP_CONTROLLER_O
);
    logic [7:0]                esr_r;
    logic [7:0]                ese_r;
    logic [7:0]                sre_r;
    logic [7:0]                pre_r;
    logic [7:0]                qer_r;
    logic [7:0]                eer_r;
    logic                      mav_r;
    logic                      rqs_r;
    iesp_pkg::iesp_ppcfg_t     ppcfg_r;
    iesp_pkg::iesp_resp_t      resp_r;
    iesp_pkg::iesp_resp_t      resp_nxt;
    logic                      pon_seen_r;
    logic                      nv_s1_r;
    logic                      nv_s2_r;
    logic                      ren_s1_r;
    logic                      ren_s2_r;
    logic                      q_full;
    logic                      q_empty;
    logic                      err_unterm;
    logic                      err_intr;
    logic                      err_dead;
    logic                      qerr;
    logic                      esr_read;
    logic                      esb;
    logic                      mss;
    logic [7:0]                stb;
    logic                      do_rst;

    iesp_queue_level #(
        .DEPTH   (QUEUE_DEPTH)
    ) u_queue (
        .clk_i   (CLOCK_I),
        .rst_i   (SYS_RST_I),
        .ce_i    (CE_I),
        .flush_i (1'b0),
        .push_i  (Q_PUSH_I),
        .pop_i   (Q_POP_I),
        .level_o (),
        .full_o  (q_full),
        .empty_o (q_empty)
    );
    assign QUEUE_FULL_O = q_full;
    assign err_unterm = EVT_I.talk_addr && EVT_I.fmt_idle && q_empty;
    assign err_intr   = EVT_I.fmt_waiting
                        && (EVT_I.pmt_read || EVT_I.multi_end);
    assign err_dead   = EVT_I.fmt_waiting && q_full && !err_intr;
    assign qerr       = err_unterm || err_intr || err_dead;

    assign esr_read = REQ_I.valid && (REQ_I.cmd == iesp_pkg::IESP_CMD_ESR_R);
    assign do_rst   = REQ_I.valid && (REQ_I.cmd == iesp_pkg::IESP_CMD_RST);
    assign esb = |(esr_r & ese_r);
    assign stb = {1'b0, 1'b0, esb, mav_r, 4'h0};
    assign mss = |(stb & sre_r);
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            nv_s1_r  <= 1'b0;
            nv_s2_r  <= 1'b0;
            ren_s1_r <= 1'b0;
            ren_s2_r <= 1'b0;
        end else if (CE_I) begin
            nv_s1_r  <= NVRAM_FAULT_I;
            nv_s2_r  <= nv_s1_r;
            ren_s1_r <= REN_I;
            ren_s2_r <= ren_s1_r;
        end
    end
    // Fault sampled once the synchroniser has settled
    logic [1:0] pon_cnt_r;
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            pon_cnt_r       <= 2'h0;
            pon_seen_r      <= 1'b0;
            NV_WARN_O       <= 1'b0;
            DEFAULTS_LOAD_O <= 1'b0;
        end else if (CE_I) begin
            DEFAULTS_LOAD_O <= do_rst;
            if (!pon_seen_r) begin
                pon_cnt_r <= pon_cnt_r + 2'h1;
                if (pon_cnt_r == 2'h2) begin
                    pon_seen_r <= 1'b1;
                    if (nv_s2_r) begin
                        NV_WARN_O       <= 1'b1;
                        DEFAULTS_LOAD_O <= 1'b1;
                    end
                end
            end
        end
    end
    // Event status register: sets win over read-clear
    logic [7:0] esr_set;
    always_comb begin
        esr_set = 8'h00;
        esr_set[iesp_pkg::EV_CME] = EVT_I.syntax_err;
        esr_set[iesp_pkg::EV_EXE] = EVT_I.exec_err;
        esr_set[iesp_pkg::EV_QYE] = qerr;
        esr_set[iesp_pkg::EV_OPC] = REQ_I.valid
            && (REQ_I.cmd == iesp_pkg::IESP_CMD_OPC);
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            esr_r <= iesp_pkg::ESR_RESET;
        end else if (CE_I) begin
            esr_r <= ((esr_read ? 8'h00 : esr_r) | esr_set)
                     & iesp_pkg::EV_USED_MASK;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            ese_r <= iesp_pkg::ZERO_RESET;
            sre_r <= iesp_pkg::ZERO_RESET;
            pre_r <= iesp_pkg::ZERO_RESET;
        end else if (CE_I && REQ_I.valid) begin
            unique case (REQ_I.cmd)
                iesp_pkg::IESP_CMD_ESE_W: begin
                    ese_r <= REQ_I.data & iesp_pkg::EV_USED_MASK;
                end
                iesp_pkg::IESP_CMD_SRE_W: begin
                    sre_r <= REQ_I.data & iesp_pkg::SB_USED_MASK;
                end
                iesp_pkg::IESP_CMD_PRE_W: begin
                    pre_r <= REQ_I.data;
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            qer_r <= iesp_pkg::ZERO_RESET;
            eer_r <= iesp_pkg::ZERO_RESET;
        end else if (CE_I) begin
            if (err_unterm) begin
                qer_r <= iesp_pkg::QE_UNTERMINATED;
            end else if (err_intr) begin
                qer_r <= iesp_pkg::QE_INTERRUPTED;
            end else if (err_dead) begin
                qer_r <= iesp_pkg::QE_DEADLOCK;
            end
            if (EVT_I.exec_err) begin
                eer_r <= EVT_I.exec_code;
            end
        end
    end
    always_comb begin
        resp_nxt = resp_r;
        unique case (resp_r)
            iesp_pkg::IESP_RESP_IDLE: begin
                if (EVT_I.resp_ready) begin
                    resp_nxt = iesp_pkg::IESP_RESP_WAIT;
                end
            end
            iesp_pkg::IESP_RESP_WAIT: begin
                if (err_intr || err_dead) begin
                    resp_nxt = iesp_pkg::IESP_RESP_IDLE;
                end else if (EVT_I.talk_addr) begin
                    resp_nxt = iesp_pkg::IESP_RESP_SEND;
                end
            end
            iesp_pkg::IESP_RESP_SEND: begin
                if (EVT_I.rmt_sent) begin
                    resp_nxt = iesp_pkg::IESP_RESP_IDLE;
                end
            end
            default: begin
                resp_nxt = iesp_pkg::IESP_RESP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            resp_r <= iesp_pkg::IESP_RESP_IDLE;
            mav_r  <= 1'b0;
        end else if (CE_I) begin
            resp_r <= resp_nxt;
            if (EVT_I.resp_ready) begin
                mav_r <= 1'b1;
            end else if (EVT_I.rmt_sent || err_intr || err_dead) begin
                mav_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            rqs_r <= 1'b0;
        end else if (CE_I) begin
            if (!mss) begin
                rqs_r <= 1'b0;
            end else if (!SPOLL_I) begin
                rqs_r <= 1'b1;
            end
        end
    end
    assign SRQ_O = rqs_r;
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            SPOLL_BYTE_O <= iesp_pkg::ZERO_RESET;
        end else if (CE_I) begin
            SPOLL_BYTE_O <= stb | {1'b0, rqs_r, 6'h00};
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            ppcfg_r <= '0;
        end else if (CE_I && PPE_VALID_I) begin
            if (PPE_BYTE_I[iesp_pkg::PPE_TAG_LSB +: 3]
                == iesp_pkg::PPE_TAG) begin
                ppcfg_r.enabled <= 1'b1;
                ppcfg_r.sense   <= PPE_BYTE_I[iesp_pkg::PPE_SENSE];
                ppcfg_r.line    <= PPE_BYTE_I[2:0];
            end
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            IST_O       <= 1'b0;
            PP_DIO_O    <= 8'h00;
            PP_DIO_OE_O <= 8'h00;
        end else if (CE_I) begin
            IST_O       <= |(pre_r & (stb | {1'b0, mss, 6'h00}));
            PP_DIO_O    <= 8'h00;
            PP_DIO_OE_O <= 8'h00;
            if (PPU_I && ppcfg_r.enabled
                && (IST_O == ppcfg_r.sense)) begin
                PP_DIO_O[ppcfg_r.line]    <= 1'b1;
                PP_DIO_OE_O[ppcfg_r.line] <= 1'b1;
            end
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            RESP_DATA_O  <= 8'h00;
            RESP_VALID_O <= 1'b0;
        end else if (CE_I) begin
            RESP_VALID_O <= 1'b0;
            if (REQ_I.valid) begin
                RESP_VALID_O <= 1'b1;
                unique case (REQ_I.cmd)
                    iesp_pkg::IESP_CMD_ESR_R: RESP_DATA_O <= esr_r;
                    iesp_pkg::IESP_CMD_ESE_R: RESP_DATA_O <= ese_r;
                    iesp_pkg::IESP_CMD_SRE_R: RESP_DATA_O <= sre_r;
                    iesp_pkg::IESP_CMD_PRE_R: RESP_DATA_O <= pre_r;
                    iesp_pkg::IESP_CMD_STB_R:
                        RESP_DATA_O <= stb | {1'b0, mss, 6'h00};
                    iesp_pkg::IESP_CMD_QER_R: RESP_DATA_O <= qer_r;
                    iesp_pkg::IESP_CMD_EER_R: RESP_DATA_O <= eer_r;
                    default: RESP_VALID_O <= 1'b0;
                endcase
            end
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            PARSER_RESET_O <= 1'b0;
            FMT_RESET_O    <= 1'b0;
        end else if (CE_I) begin
            PARSER_RESET_O <= err_unterm || EVT_I.syntax_err;
            FMT_RESET_O    <= err_intr || err_dead;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            REMOTE_O <= 1'b0;
        end else if (CE_I) begin
            if (!ren_s2_r || LOCAL_KEY_I) begin
                REMOTE_O <= 1'b0;
            end else if (LISTEN_CMD_I) begin
                REMOTE_O <= 1'b1;
            end
        end
    end
    assign KEYS_ENABLED_O   = !REMOTE_O;
    assign CAP_TALKER_O     = iesp_pkg::CAP_TALKER;
    assign CAP_LISTENER_O   = iesp_pkg::CAP_LISTENER;
    assign CAP_CONTROLLER_O = iesp_pkg::CAP_CONTROLLER;
endmodule

// ### test/iesp_status_poll_asserts.sv
// Port-level assertions for the status and poll block
`timescale 1ns/1ps
module iesp_status_poll_asserts (
    input  wire logic                CLOCK_I,
    input  wire logic                SYS_RST_I,
    input  wire logic                CE_I,
    input  wire iesp_pkg::iesp_req_t REQ_I,
    input  wire iesp_pkg::iesp_evt_t EVT_I,
    input  wire logic                PPU_I,
    input  wire logic                RESP_VALID_O,
    input  wire logic [7:0]          SPOLL_BYTE_O,
    input  wire logic                SRQ_O,
    input  wire logic [7:0]          PP_DIO_OE_O,
    input  wire logic                PARSER_RESET_O,
    input  wire logic                FMT_RESET_O,
    input  wire logic                QUEUE_FULL_O,
    input  wire logic                REMOTE_O,
    input  wire logic                KEYS_ENABLED_O,
    input  wire logic [15:0]         CAP_TALKER_O,
    input  wire logic [15:0]         CAP_CONTROLLER_O
);
    logic rd;
    assign rd = CE_I && REQ_I.valid && (REQ_I.cmd inside {
        iesp_pkg::IESP_CMD_ESE_R, iesp_pkg::IESP_CMD_ESR_R,
        iesp_pkg::IESP_CMD_SRE_R, iesp_pkg::IESP_CMD_STB_R,
        iesp_pkg::IESP_CMD_PRE_R, iesp_pkg::IESP_CMD_QER_R,
        iesp_pkg::IESP_CMD_EER_R});
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I);
    property p_rd; rd |=> RESP_VALID_O; endproperty
    a_rd: assert property (p_rd)
        else $error("no answer");
    property p_nord; CE_I && !rd |=> !RESP_VALID_O; endproperty
    a_nord: assert property (p_nord)
        else $error("stray answer");
    property p_syn; CE_I && EVT_I.syntax_err |=> PARSER_RESET_O; endproperty
    a_syn: assert property (p_syn)
        else $error("no parser reset");
    property p_intr;
        CE_I && EVT_I.fmt_waiting && EVT_I.pmt_read && !EVT_I.talk_addr
            |=> FMT_RESET_O;
    endproperty
    a_intr: assert property (p_intr)
        else $error("no reset on intr");
    property p_dead;
        CE_I && EVT_I.fmt_waiting && !EVT_I.talk_addr
            && $rose(QUEUE_FULL_O) |=> FMT_RESET_O;
    endproperty
    a_dead: assert property (p_dead)
        else $error("no reset on deadlock");
    property p_rqs;
        $past(CE_I) |-> SPOLL_BYTE_O[6] == $past(SRQ_O);
    endproperty
    a_rqs: assert property (p_rqs)
        else $error("poll bit 6 wrong");
    property p_sbz; (SPOLL_BYTE_O & 8'h8f) == 8'h00; endproperty
    a_sbz: assert property (p_sbz)
        else $error("unused bit set");
    property p_keys; KEYS_ENABLED_O == !REMOTE_O; endproperty
    a_keys: assert property (p_keys)
        else $error("keys wrong");
    property p_pwr;
        disable iff (1'b0) SYS_RST_I ##1 !SYS_RST_I
            |-> !REMOTE_O && !SRQ_O && KEYS_ENABLED_O;
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("bad reset state");
    property p_pp; !PPU_I [*2] |-> PP_DIO_OE_O == 8'h00; endproperty
    a_pp: assert property (p_pp)
        else $error("stray poll drive");
    property p_cap;
        CAP_TALKER_O == iesp_pkg::CAP_TALKER
            && CAP_CONTROLLER_O == iesp_pkg::CAP_CONTROLLER;
    endproperty
    a_cap: assert property (p_cap)
        else $error("bad capability");
    c_rd: cover property (rd ##1 RESP_VALID_O);
    c_dead: cover property (EVT_I.fmt_waiting && QUEUE_FULL_O);
    c_pp: cover property (PPU_I && PP_DIO_OE_O != 8'h00);
endmodule

bind iesp_status_poll iesp_status_poll_asserts u_iesp_status_poll_asserts (
    .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
    .REQ_I(REQ_I), .EVT_I(EVT_I), .PPU_I(PPU_I),
    .RESP_VALID_O(RESP_VALID_O), .SPOLL_BYTE_O(SPOLL_BYTE_O),
    .SRQ_O(SRQ_O), .PP_DIO_OE_O(PP_DIO_OE_O),
    .PARSER_RESET_O(PARSER_RESET_O), .FMT_RESET_O(FMT_RESET_O),
    .QUEUE_FULL_O(QUEUE_FULL_O), .REMOTE_O(REMOTE_O),
    .KEYS_ENABLED_O(KEYS_ENABLED_O), .CAP_TALKER_O(CAP_TALKER_O),
    .CAP_CONTROLLER_O(CAP_CONTROLLER_O));

// ### test/iesp_ctrl_model.sv
// Bus controller model: poll configuration and parallel poll cycles
`timescale 1ns/1ps
module iesp_ctrl_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pp_oe_i,
    output logic            ppe_valid_o,
    output logic [7:0]      ppe_byte_o,
    output logic            ppu_o,
    output logic            spoll_o,
    output logic            ren_o
);
    initial begin
        ppe_valid_o = 1'b0;
        ppe_byte_o = 8'h00;
        ppu_o = 1'b0;
        spoll_o = 1'b0;
        ren_o = 1'b1;
    end
    // One enable byte, valid for one clock, then its complement with valid low
    task automatic configure(input logic [7:0] b);
        @(posedge clk_i);
        #1;
        ppe_valid_o = 1'b1;
        ppe_byte_o = b;
        @(posedge clk_i);
        #1;
        ppe_valid_o = 1'b0;
        ppe_byte_o = ~b;
    endtask
    task automatic poll(output logic [7:0] oe);
        @(posedge clk_i);
        #1;
        ppu_o = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        oe = pp_oe_i;
        ppu_o = 1'b0;
    endtask
endmodule

// ### test/iesp_status_poll_tb.sv
// Self-checking bench for the status and poll block
`timescale 1ns/1ps
module iesp_status_poll_tb;
    localparam int unsigned QD = 8;
    logic                clk;
    logic                rst;
    iesp_pkg::iesp_req_t req;
    iesp_pkg::iesp_evt_t evt;
    logic                q_push, q_pop, ppe_valid, ppu, spoll, ren;
    logic                listen, lkey, nvf, resp_valid, srq, ist, ce, dflt;
    logic                prs_rst, fmt_rst, full, remote, keys, nv_warn;
    logic                prs_s, fmt_s;
    logic [7:0]          ppe_byte, resp_data, spoll_byte, pp_dio, pp_oe;
    logic [7:0]          oe;
    logic [15:0]         cap_l;
    logic [7:0]          ppb[4] = '{8'h69, 8'h61, 8'h59, 8'he9};
    logic [3:0]          ppx = 4'b1001;
    int                  n_mismatch = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;

    iesp_status_poll #(.QUEUE_DEPTH(QD)) u_iesp_status_poll (
        .CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .REQ_I(req),
        .EVT_I(evt), .Q_PUSH_I(q_push), .Q_POP_I(q_pop),
        .PPE_VALID_I(ppe_valid), .PPE_BYTE_I(ppe_byte), .PPU_I(ppu),
        .SPOLL_I(spoll), .REN_I(ren), .LISTEN_CMD_I(listen),
        .LOCAL_KEY_I(lkey), .NVRAM_FAULT_I(nvf), .RESP_DATA_O(resp_data),
        .RESP_VALID_O(resp_valid), .SPOLL_BYTE_O(spoll_byte),
        .SRQ_O(srq), .IST_O(ist), .PP_DIO_O(pp_dio), .PP_DIO_OE_O(pp_oe),
        .PARSER_RESET_O(prs_rst), .FMT_RESET_O(fmt_rst),
        .QUEUE_FULL_O(full), .REMOTE_O(remote), .KEYS_ENABLED_O(keys),
        .NV_WARN_O(nv_warn), .DEFAULTS_LOAD_O(dflt), .CAP_TALKER_O(),
        .CAP_LISTENER_O(cap_l), .CAP_CONTROLLER_O());
    iesp_ctrl_model u_iesp_ctrl_model (
        .clk_i(clk), .pp_oe_i(pp_oe), .ppe_valid_o(ppe_valid),
        .ppe_byte_o(ppe_byte), .ppu_o(ppu), .spoll_o(spoll), .ren_o(ren));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] d,
                       output logic v, output logic [7:0] q);
        req = '{1'b1, iesp_pkg::iesp_cmd_t'(c), d};
        @(posedge clk);
        #1;
        v = resp_valid;
        q = resp_data;
        req.valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [3:0] c, input logic [7:0] e);
        logic       v;
        logic [7:0] q;
        cmd(c, 8'h00, v, q);
        chk($sformatf("rd %h", c), {7'h0, v, q}, {8'h01, e});
    endtask
    task automatic wr(input logic [3:0] c, input logic [7:0] d);
        logic       v;
        logic [7:0] q;
        cmd(c, d, v, q);
        chk($sformatf("wr %h", c), 16'(v), 16'h0);
    endtask
    task automatic pulse(input iesp_pkg::iesp_evt_t e);
        evt = e;
        @(posedge clk);
        #1;
        evt = '0;
        prs_s = prs_rst;
        fmt_s = fmt_rst;
        @(posedge clk);
        #1;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        evt = '0;
        {q_push, q_pop, listen, lkey, nvf} = '0;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("keys", 16'(keys), 16'h1);
        chk("listener", cap_l, iesp_pkg::CAP_LISTENER);
        rd(4'h3, 8'h80);
        rd(4'h3, 8'h00);
        rd(4'ha, 8'h00);
        rd(4'hb, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h8, 8'h00);
        wr(4'h1, 8'hff);
        rd(4'h2, 8'hb5);
        wr(4'h4, 8'hff);
        rd(4'h5, 8'h30);
        wr(4'h7, 8'h40);
        rd(4'h8, 8'h40);
        wr(4'h9, 8'h00);
        rd(4'h6, 8'h60);
        chk("poll", {6'h0, srq, ist, spoll_byte}, 16'h0360);
        foreach (ppb[i]) begin
            u_iesp_ctrl_model.configure(ppb[i]);
            u_iesp_ctrl_model.poll(oe);
            chk("pp", {7'h0, oe != 8'h00, pp_dio & oe}, {7'h0, ppx[i], oe});
        end
        rd(4'h3, 8'h01);
        rd(4'h6, 8'h00);
        chk("idle", {6'h0, srq, ist, spoll_byte}, 16'h0);
        pulse('{syntax_err:1'b1, exec_err:1'b1, exec_code:8'h2a,
                default:'0});
        chk("parser reset", 16'(prs_s), 16'h1);
        rd(4'h3, 8'h30);
        rd(4'hb, 8'h2a);
        pulse('{resp_ready:1'b1, default:'0});
        rd(4'h6, 8'h50);
        pulse('{rmt_sent:1'b1, default:'0});
        rd(4'h6, 8'h00);
        pulse('{talk_addr:1'b1, fmt_idle:1'b1, queue_empty:1'b1,
                default:'0});
        chk("parser reset", 16'(prs_s), 16'h1);
        rd(4'ha, 8'h03);
        rd(4'h3, 8'h04);
        pulse('{fmt_waiting:1'b1, pmt_read:1'b1, default:'0});
        chk("fmt reset", 16'(fmt_s), 16'h1);
        rd(4'ha, 8'h01);
        evt.fmt_waiting = 1'b1;
        q_push = 1'b1;
        repeat (QD - 1) @(posedge clk);
        #1;
        chk("full early", 16'(full), 16'h0);
        tick();
        chk("full", 16'(full), 16'h1);
        q_push = 1'b0;
        tick();
        chk("fmt reset", 16'(fmt_rst), 16'h1);
        evt.fmt_waiting = 1'b0;
        q_pop = 1'b1;
        tick();
        q_pop = 1'b0;
        rd(4'ha, 8'h02);
        rd(4'h3, 8'h04);
        ce = 1'b0;
        wr(4'h9, 8'h00);
        ce = 1'b1;
        rd(4'h3, 8'h00);
        listen = 1'b1;
        tick();
        listen = 1'b0;
        tick();
        chk("remote", {14'h0, remote, keys}, 16'h2);
        lkey = 1'b1;
        tick();
        lkey = 1'b0;
        tick();
        chk("local", {14'h0, remote, keys}, 16'h1);
        nvf = 1'b1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("nv warn", {14'h0, nv_warn, dflt}, 16'h3);
        rd(4'h2, 8'h00);
        rd(4'h3, 8'h80);
        test_done();
    end
endmodule
